// *** emb_bus_ctrl.sv ***
`timescale 1ns/100ps
`default_nettype none
`include "emb_consts.svh"


// ----------------------------------------------------------------------
// External memory bus sequencer
// ----------------------------------------------------------------------
module emb_bus_ctrl #(
	parameter logic [15:0] ONCHIP_LIMIT  = `EMB_ONCHIP_LIMIT,   // Top on-chip address
	parameter int          STROBE_CYCLES = `EMB_STROBE_CYCLES   // Strobe width, cycles
) (
	input  wire logic        i_ref_clk,               // 10 MHz clock
	input  wire logic        i_reset_n,               // Synchronous reset, active low
	// Core requests
	input  wire logic        i_fetch_req,             // Fetch request
	input  wire logic [15:0] i_instruction_pointer,   // Fetch address
	input  wire logic        i_data_req,              // Data access request
	input  wire logic        i_data_write,            // 1: write, 0: read
	input  wire logic        i_data_wide,             // 1: pointer, 0: index register
	input  wire logic [15:0] i_data_pointer_reg,      // 16-bit data address
	input  wire logic [7:0]  i_indirect_index_reg,    // 8-bit data address
	input  wire logic [7:0]  i_wdata,                 // Write data
	output logic             o_busy,                  // Bus cycle in progress
	output logic             o_done,                  // Pulse: cycle finished
	output logic             o_fetch_internal,        // Pulse: fetch is on chip
	output logic [7:0]       o_rdata,                 // Read or fetched byte
	input  wire logic        i_external_fetch_select_n,  // Low: all fetches external
	// Software port latch access
	input  wire logic        i_low_port_wr,           // Write low port latch
	input  wire logic [7:0]  i_low_port_wdata,        // Low port latch data
	input  wire logic        i_high_port_wr,          // Write high port latch
	input  wire logic [7:0]  i_high_port_wdata,       // High port latch data
	output logic [7:0]       o_low_port_latch,        // Low port latch
	output logic [7:0]       o_high_port_latch,       // High port latch
	output logic             o_low_port_wr_refused,   // Pulse: low write dropped
	// Memory bus pins
	output logic             o_ale,                   // Address latch pulse
	output logic             o_program_fetch_strobe_n,  // Fetch strobe, active low
	output logic             o_read_strobe_pin_n,     // Data read strobe, active low
	output logic             o_write_strobe_pin_n,    // Data write strobe, active low
	input  wire logic [7:0]  i_low_addr_data_port,    // Low port pin level
	output logic [7:0]       o_low_addr_data_port,    // Low port drive value
	output logic [7:0]       o_low_addr_data_port_oe, // Low port drive enable
	output logic [7:0]       o_high_addr_port,        // High port drive value
	output logic [7:0]       o_high_addr_port_oe,     // High port drive enable
	output logic [7:0]       o_high_addr_port_strong  // High port strong pullup
);

	// ------------------------------------------------------------------
	// Declarations
	// ------------------------------------------------------------------
	localparam logic [`EMB_CNT_W-1:0] STB_LAST = `EMB_CNT_W'(STROBE_CYCLES - 1);

	emb_pkg::emb_seq_state_t r;        // Registered state
	emb_pkg::emb_seq_state_t next_r;   // Next state
	logic                    fetch_ext;  // Fetch address lies off chip
	logic                    in_bus;     // Sequencer away from idle
	logic                    addr_phase; // Low port carries address
	logic                    high_addr;  // High port carries address

	emb_latch_if lat ();  // Carrier to the port latches

	// Decides whether a fetch goes off chip
	function automatic logic is_external(
		input logic        sel_n,
		input logic [15:0] ip
	);
		is_external = !sel_n || (ip > ONCHIP_LIMIT);
	endfunction

	// ------------------------------------------------------------------
	// Sequencer
	// ------------------------------------------------------------------

	// Fetch destination
	assign fetch_ext = is_external(i_external_fetch_select_n, i_instruction_pointer);

	// Next state of the bus cycle
	always_comb begin
		next_r = r;
		next_r.done = 1'b0;
		next_r.internal = 1'b0;
		case (r.state)
			emb_pkg::S_IDLE: begin
				// Fetch wins over data when both are asked
				if (i_fetch_req && fetch_ext) begin
					next_r.state    = emb_pkg::S_ALE;
					next_r.is_fetch = 1'b1;
					next_r.is_write = 1'b0;
					next_r.wide     = 1'b1;
					next_r.addr     = i_instruction_pointer;
					next_r.ext_exec = 1'b1;
					next_r.pc_high  = i_instruction_pointer[15:8];
				end else if (i_fetch_req) begin
					// On-chip fetch, no bus cycle
					next_r.internal = 1'b1;
					next_r.ext_exec = 1'b0;
				end else if (i_data_req) begin
					next_r.state    = emb_pkg::S_ALE;
					next_r.is_fetch = 1'b0;
					next_r.is_write = i_data_write;
					next_r.wide     = i_data_wide;
					next_r.wdata    = i_wdata;
					// Pointer or index register as address
					if (i_data_wide) begin
						next_r.addr = i_data_pointer_reg;
					end else begin
						next_r.addr = {`EMB_BYTE_ZERO, i_indirect_index_reg};
					end
				end
			end
			emb_pkg::S_ALE: begin
				// Address stays on the low port past the pulse fall
				next_r.state = emb_pkg::S_ADDR;
			end
			emb_pkg::S_ADDR: begin
				next_r.cnt = STB_LAST;
				// Writes put data out one cycle before the strobe
				if (r.is_write) begin
					next_r.state = emb_pkg::S_SETUP;
				end else begin
					next_r.state = emb_pkg::S_STROBE;
				end
			end
			emb_pkg::S_SETUP: begin
				next_r.state = emb_pkg::S_STROBE;
			end
			emb_pkg::S_STROBE: begin
				if (r.cnt == '0) begin
					next_r.state = emb_pkg::S_RELEASE;
					// Capture on the edge that releases the strobe
					if (!r.is_write) begin
						next_r.rdata = i_low_addr_data_port;
					end
				end else begin
					next_r.cnt = r.cnt - `EMB_CNT_W'(1);
				end
			end
			emb_pkg::S_RELEASE: begin
				// Strobe inactive, write data still held
				next_r.state = emb_pkg::S_IDLE;
				next_r.done  = 1'b1;
			end
			default: begin
				next_r.state = emb_pkg::S_IDLE;
			end
		endcase
	end

	// State register
	always_ff @(posedge i_ref_clk) begin
		if (!i_reset_n) begin
			r.state    <= emb_pkg::S_IDLE;
			r.is_fetch <= 1'b0;
			r.is_write <= 1'b0;
			r.wide     <= 1'b0;
			r.addr     <= `EMB_ADDR_ZERO;
			r.wdata    <= `EMB_BYTE_ZERO;
			r.rdata    <= `EMB_BYTE_ZERO;
			r.cnt      <= '0;
			r.ext_exec <= 1'b0;
			r.pc_high  <= `EMB_BYTE_ZERO;
			r.done     <= 1'b0;
			r.internal <= 1'b0;
		end else begin
			r <= next_r;
		end
	end

	// ------------------------------------------------------------------
	// Port latches
	// ------------------------------------------------------------------

	// Latch controls over the carrier
	assign lat.access_start = (r.state == emb_pkg::S_ALE);
	assign lat.ext_in_use   = r.ext_exec || (in_bus && r.is_fetch);
	assign lat.low_wr       = i_low_port_wr;
	assign lat.low_wdata    = i_low_port_wdata;
	assign lat.high_wr      = i_high_port_wr;
	assign lat.high_wdata   = i_high_port_wdata;

	emb_port_latch u_latch (
		.i_ref_clk (i_ref_clk),
		.i_reset_n (i_reset_n),
		.lat       (lat)
	);

	// ------------------------------------------------------------------
	// Pins
	// ------------------------------------------------------------------
	assign in_bus     = (r.state != emb_pkg::S_IDLE);
	assign addr_phase = (r.state == emb_pkg::S_ALE) || (r.state == emb_pkg::S_ADDR);
	assign high_addr  = in_bus && r.wide;

	// Strobes
	always_comb begin
		o_ale = (r.state == emb_pkg::S_ALE);
		// Fetch strobe for code only, never in data cycles
		o_program_fetch_strobe_n = !((r.state == emb_pkg::S_STROBE) && r.is_fetch);
		o_read_strobe_pin_n = !((r.state == emb_pkg::S_STROBE) && !r.is_fetch
			&& !r.is_write);
		o_write_strobe_pin_n = !((r.state == emb_pkg::S_STROBE) && r.is_write);
	end

	// Low port: address, then write data, push-pull; released for reads and fetches
	always_comb begin
		if (addr_phase) begin
			o_low_addr_data_port    = r.addr[7:0];
			o_low_addr_data_port_oe = `EMB_LATCH_ALL_ONES;
		end else if (in_bus && r.is_write) begin
			o_low_addr_data_port    = r.wdata;
			o_low_addr_data_port_oe = `EMB_LATCH_ALL_ONES;
		end else if (in_bus) begin
			// Released for the memory to drive
			o_low_addr_data_port    = `EMB_BYTE_ZERO;
			o_low_addr_data_port_oe = `EMB_BYTE_ZERO;
		end else begin
			// Idle: open drain, pulls low where latch holds zero
			o_low_addr_data_port    = `EMB_BYTE_ZERO;
			o_low_addr_data_port_oe = ~lat.low_latch;
		end
	end

	// High port: address byte, fetch byte or latch
	always_comb begin
		if (high_addr) begin
			// Whole cycle, strong drive for ones
			o_high_addr_port        = r.addr[15:8];
			o_high_addr_port_oe     = `EMB_LATCH_ALL_ONES;
			o_high_addr_port_strong = r.addr[15:8];
		end else if (!in_bus && r.ext_exec) begin
			// Between bus cycles while running off chip: code address high byte
			o_high_addr_port        = r.pc_high;
			o_high_addr_port_oe     = `EMB_LATCH_ALL_ONES;
			o_high_addr_port_strong = r.pc_high;
		end else begin
			// Latch on the pins, usable as a data page
			o_high_addr_port        = lat.high_latch;
			o_high_addr_port_oe     = ~lat.high_latch;
			o_high_addr_port_strong = `EMB_BYTE_ZERO;
		end
	end

	// ------------------------------------------------------------------
	// Core side outputs
	// ------------------------------------------------------------------
	assign o_busy                = in_bus;
	assign o_done                = r.done;
	assign o_fetch_internal      = r.internal;
	assign o_rdata               = r.rdata;
	assign o_low_port_latch      = lat.low_latch;
	assign o_high_port_latch     = lat.high_latch;
	assign o_low_port_wr_refused = lat.low_refused;

endmodule

`default_nettype wire

// *** emb_consts.svh ***
`ifndef EMB_CONSTS_SVH
`define EMB_CONSTS_SVH

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define EMB_CLK_PERIOD_NS 100
// Least width of a read, write or fetch strobe, in ns
`define EMB_STROBE_MIN_NS 300
// Strobe width in clock cycles, rounded up, never below one
`define EMB_STROBE_CYCLES \
	(((`EMB_STROBE_MIN_NS + `EMB_CLK_PERIOD_NS - 1) / `EMB_CLK_PERIOD_NS) < 1 ? 1 : \
	((`EMB_STROBE_MIN_NS + `EMB_CLK_PERIOD_NS - 1) / `EMB_CLK_PERIOD_NS))
`define EMB_CNT_W 4

// ----------------------------------------------------------------------
// Address map and widths
// ----------------------------------------------------------------------
`define EMB_ONCHIP_LIMIT 16'h1FFF
`define EMB_ADDR_W 16
`define EMB_BYTE_W 8

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define EMB_LATCH_RESET 8'hFF
`define EMB_LATCH_ALL_ONES 8'hFF
`define EMB_BYTE_ZERO 8'h00
`define EMB_ADDR_ZERO 16'h0000

`endif

// *** emb_pkg.sv ***
`include "emb_consts.svh"

package emb_pkg;

	// ------------------------------------------------------------------
	// Bus sequencer states
	// ------------------------------------------------------------------
	typedef enum logic [2:0] {
		S_IDLE,
		S_ALE,
		S_ADDR,
		S_SETUP,
		S_STROBE,
		S_RELEASE
	} emb_state_t;

	// ------------------------------------------------------------------
	// Port latch state
	// ------------------------------------------------------------------
	typedef struct packed {
		logic [`EMB_BYTE_W-1:0] low_latch;   // Low address/data port latch
		logic [`EMB_BYTE_W-1:0] high_latch;  // High address port latch
		logic                   refused;     // Low port write was dropped
	} emb_latch_state_t;

	// ------------------------------------------------------------------
	// Sequencer state
	// ------------------------------------------------------------------
	typedef struct packed {
		emb_state_t             state;       // Bus phase
		logic                   is_fetch;    // Cycle is a program fetch
		logic                   is_write;    // Cycle is a data write
		logic                   wide;        // Cycle carries a 16-bit address
		logic [`EMB_ADDR_W-1:0] addr;        // Address of the cycle
		logic [`EMB_BYTE_W-1:0] wdata;       // Write data
		logic [`EMB_BYTE_W-1:0] rdata;       // Captured read data
		logic [`EMB_CNT_W-1:0]  cnt;         // Strobe cycle counter
		logic                   ext_exec;    // Executing from external memory
		logic [`EMB_BYTE_W-1:0] pc_high;     // High byte of last external fetch
		logic                   done;        // Cycle finished pulse
		logic                   internal;    // Fetch served on chip pulse
	} emb_seq_state_t;

endpackage

// *** emb_latch_if.sv ***
`timescale 1ns/100ps
`default_nettype none
`include "emb_consts.svh"

// ----------------------------------------------------------------------
// Carrier between the sequencer and the port latches
// ----------------------------------------------------------------------
interface emb_latch_if;
	logic                   access_start;  // Pulse: external access begins
	logic                   ext_in_use;    // Level: external program memory in use
	logic                   low_wr;        // Software write to low port latch
	logic [`EMB_BYTE_W-1:0] low_wdata;     // Data for low port latch
	logic                   high_wr;       // Software write to high port latch
	logic [`EMB_BYTE_W-1:0] high_wdata;    // Data for high port latch
	logic [`EMB_BYTE_W-1:0] low_latch;     // Low port latch contents
	logic [`EMB_BYTE_W-1:0] high_latch;    // High port latch contents
	logic                   low_refused;   // Pulse: low port write dropped

	modport seq (
		output access_start, ext_in_use, low_wr, low_wdata, high_wr, high_wdata,
		input  low_latch, high_latch, low_refused
	);
	modport latch (
		input  access_start, ext_in_use, low_wr, low_wdata, high_wr, high_wdata,
		output low_latch, high_latch, low_refused
	);
endinterface

`default_nettype wire

// *** emb_port_latch.sv ***
`timescale 1ns/100ps
`default_nettype none
`include "emb_consts.svh"

// ----------------------------------------------------------------------
// Port latches seen by software
// ----------------------------------------------------------------------
module emb_port_latch (
	input  wire logic  i_ref_clk,   // System clock
	input  wire logic  i_reset_n,   // Synchronous reset, active low
	emb_latch_if.latch lat          // Latch carrier
);

	emb_pkg::emb_latch_state_t r;       // Registered state
	emb_pkg::emb_latch_state_t next_r;  // Next state

	// Next state of both latches
	always_comb begin
		next_r = r;
		next_r.refused = 1'b0;
		// High latch is never touched by bus cycles
		if (lat.high_wr) begin
			next_r.high_latch = lat.high_wdata;
		end
		// Low latch writes are dropped while external code is in use
		if (lat.low_wr && lat.ext_in_use) begin
			next_r.refused = 1'b1;
		end else if (lat.low_wr) begin
			next_r.low_latch = lat.low_wdata;
		end
		// Every external access overwrites the low latch with ones
		if (lat.access_start) begin
			next_r.low_latch = `EMB_LATCH_ALL_ONES;
		end
	end

	// State register
	always_ff @(posedge i_ref_clk) begin
		if (!i_reset_n) begin
			r.low_latch  <= `EMB_LATCH_RESET;
			r.high_latch <= `EMB_LATCH_RESET;
			r.refused    <= 1'b0;
		end else begin
			r <= next_r;
		end
	end

	assign lat.low_latch   = r.low_latch;
	assign lat.high_latch  = r.high_latch;
	assign lat.low_refused = r.refused;

endmodule

`default_nettype wire

// *** emb_bus_monitor.sv ***
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------------------------------------
// Bus pin checker
// ----------------------------------------------------------------------
module emb_bus_monitor #(
	parameter logic [15:0] ONCHIP_LIMIT  = 16'h1FFF, // Top on-chip address
	parameter int          STROBE_CYCLES = 3         // Strobe width
) (
	input wire logic        i_ref_clk,                 // Clock
	input wire logic        i_reset_n,                 // Reset
	input wire logic        i_fetch_req,               // Fetch request
	input wire logic [15:0] i_instruction_pointer,     // Fetch address
	input wire logic        i_external_fetch_select_n, // Select
	input wire logic        i_low_port_wr,             // Low write
	input wire logic        o_busy,                    // Busy
	input wire logic        o_fetch_internal,          // On chip
	input wire logic [7:0]  o_low_port_latch,          // Low latch
	input wire logic        o_low_port_wr_refused,     // Dropped
	input wire logic        o_ale,                     // Latch pulse
	input wire logic        o_program_fetch_strobe_n,  // Fetch strobe
	input wire logic        o_read_strobe_pin_n,       // Read strobe
	input wire logic        o_write_strobe_pin_n,      // Write strobe
	input wire logic [7:0]  o_low_addr_data_port,      // Low drive
	input wire logic [7:0]  o_low_addr_data_port_oe,   // Low enable
	input wire logic [7:0]  o_high_addr_port,          // High drive
	input wire logic [7:0]  o_high_addr_port_strong    // Strong pullup
);
	logic       rd_idle;  // No read strobe low
	logic [3:0] low_cnt;  // Cycles a read strobe has been low
	assign rd_idle = o_read_strobe_pin_n && o_program_fetch_strobe_n;
	default clocking cb @(posedge i_ref_clk); endclocking
	default disable iff (!i_reset_n);
	// Counts the width of each read or fetch strobe
	always_ff @(posedge i_ref_clk) begin
		if (!i_reset_n || rd_idle)
			low_cnt <= 4'h0;
		else
			low_cnt <= low_cnt + 4'h1;
	end
	property p_excl; $onehot0({~o_program_fetch_strobe_n, ~o_read_strobe_pin_n, ~o_write_strobe_pin_n}); endproperty
	a_excl: assert property (p_excl) else $error("Two strobes active");
	property p_strong; !o_program_fetch_strobe_n |-> o_high_addr_port_strong == o_high_addr_port; endproperty
	a_strong: assert property (p_strong) else $error("High port ones not strong");
	property p_ale_addr; $fell(o_ale) |-> o_low_addr_data_port_oe == 8'hFF && $stable(o_low_addr_data_port); endproperty
	a_ale_addr: assert property (p_ale_addr) else $error("Low address moved at latch");
	property p_ale_ones; $fell(o_ale) |-> o_low_port_latch == 8'hFF; endproperty
	a_ale_ones: assert property (p_ale_ones) else $error("Low latch not all ones");
	property p_wr_setup; $fell(o_write_strobe_pin_n) |-> $past(o_low_addr_data_port_oe) == 8'hFF && $stable(o_low_addr_data_port); endproperty
	a_wr_setup: assert property (p_wr_setup) else $error("Write data late");
	property p_wr_hold; $rose(o_write_strobe_pin_n) |-> o_low_addr_data_port_oe == 8'hFF && $stable(o_low_addr_data_port); endproperty
	a_wr_hold: assert property (p_wr_hold) else $error("Write data dropped early");
	property p_rd_free; !rd_idle |-> o_low_addr_data_port_oe == 8'h00; endproperty
	a_rd_free: assert property (p_rd_free) else $error("Low port driven during read");
	property p_rd_width; $rose(rd_idle) |-> low_cnt == 4'(STROBE_CYCLES); endproperty
	a_rd_width: assert property (p_rd_width) else $error("Read strobe width wrong");
	property p_sel_ext; !o_busy && i_fetch_req && !i_external_fetch_select_n |=> o_ale && !o_fetch_internal; endproperty
	a_sel_ext: assert property (p_sel_ext) else $error("Fetch not external");
	property p_onchip; !o_busy && i_fetch_req && i_external_fetch_select_n && i_instruction_pointer <= ONCHIP_LIMIT |=> o_fetch_internal && !o_ale; endproperty
	a_onchip: assert property (p_onchip) else $error("On-chip fetch went out");
	property p_offchip; !o_busy && i_fetch_req && i_external_fetch_select_n && i_instruction_pointer > ONCHIP_LIMIT |=> o_ale; endproperty
	a_offchip: assert property (p_offchip) else $error("Fetch above limit not external");
	property p_refuse; i_low_port_wr && !o_program_fetch_strobe_n |=> o_low_port_wr_refused && $stable(o_low_port_latch); endproperty
	a_refuse: assert property (p_refuse) else $error("Low write during fetch taken");
endmodule

bind emb_bus_ctrl emb_bus_monitor #(.ONCHIP_LIMIT(ONCHIP_LIMIT), .STROBE_CYCLES(STROBE_CYCLES))
	emb_bus_monitor_i (.i_ref_clk(i_ref_clk), .i_reset_n(i_reset_n), .i_fetch_req(i_fetch_req),
	.i_instruction_pointer(i_instruction_pointer), .i_low_port_wr(i_low_port_wr),
	.i_external_fetch_select_n(i_external_fetch_select_n), .o_busy(o_busy),
	.o_fetch_internal(o_fetch_internal), .o_low_port_latch(o_low_port_latch),
	.o_low_port_wr_refused(o_low_port_wr_refused), .o_ale(o_ale),
	.o_program_fetch_strobe_n(o_program_fetch_strobe_n), .o_read_strobe_pin_n(o_read_strobe_pin_n),
	.o_write_strobe_pin_n(o_write_strobe_pin_n), .o_low_addr_data_port(o_low_addr_data_port),
	.o_low_addr_data_port_oe(o_low_addr_data_port_oe), .o_high_addr_port(o_high_addr_port),
	.o_high_addr_port_strong(o_high_addr_port_strong));
`default_nettype wire

// *** emb_mem_model.sv ***
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------------------------------------
// External code and data memory with address latch
// ----------------------------------------------------------------------
module emb_mem_model (
	input  wire logic        i_clk,    // Clock
	input  wire logic        i_ale,    // Address latch pulse
	input  wire logic        i_fs_n,   // Fetch strobe
	input  wire logic        i_rd_n,   // Read strobe
	input  wire logic        i_wr_n,   // Write strobe
	input  wire logic [7:0]  i_lo,     // Low port drive value
	input  wire logic [7:0]  i_lo_oe,  // Low port drive enable
	input  wire logic [7:0]  i_hi,     // High port value
	output logic      [7:0]  o_pin,    // Resolved low port level
	output logic      [15:0] o_addr    // Latched address
);
	logic [7:0] dmem [0:65535]; // Data memory
	logic [7:0] last = 8'h00;   // Level seen last cycle
	logic [7:0] drv;            // Memory side drive
	// Latch closes on the falling edge of the pulse
	always @(negedge i_ale) o_addr = {i_hi, o_pin};
	// Byte stored as the write strobe releases
	always @(posedge i_wr_n) dmem[o_addr] = o_pin;
	// Released bus shows a pattern that flips every cycle
	always @(posedge i_clk) last <= o_pin;
	// Data comes out only while a read strobe is low
	always_comb begin
		if (!i_fs_n)
			drv = ~o_addr[7:0] ^ o_addr[15:8];
		else if (!i_rd_n)
			drv = dmem[o_addr];
		else
			drv = ~last;
	end
	assign o_pin = (i_lo_oe & i_lo) | (~i_lo_oe & drv);
endmodule
`default_nettype wire

// *** tb_top.sv ***
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------------------------------------
// Bench for the external memory bus sequencer
// ----------------------------------------------------------------------
module tb_top;
	logic        clk = 1'b0;     // 10 MHz clock
	logic        rst_n = 1'b0;   // Reset, active low
	logic        f_req = 1'b0;   // Fetch request
	logic        d_req = 1'b0;   // Data request
	logic        d_wr = 1'b0;    // Data write
	logic        d_wide = 1'b0;  // Wide address
	logic        sel_n = 1'b1;   // External fetch select
	logic        lw = 1'b0;      // Low latch write
	logic        hw = 1'b0;      // High latch write
	logic [15:0] adr = 16'h0000; // Request address
	logic [7:0]  wd = 8'h00;     // Write data
	logic [7:0]  lwd = 8'h00;    // Low latch data
	logic [7:0]  hwd = 8'h00;    // High latch data
	logic        busy, done, f_int, refused, ale, fs_n, rd_n, wr_n; // Flags
	logic [7:0]  rdata, lat_lo, lat_hi, pin, lo, lo_oe, hi, hi_oe, hi_st; // Bytes
	logic [15:0] maddr;          // Address latched by memory
	logic [25:0] notes[$];       // Expected answers
	int          miscompares = 0; // Mismatches
	int          checks_done = 0; // Comparisons
	always #50 clk = ~clk;
	emb_bus_ctrl emb_bus_ctrl_i (
		.i_ref_clk(clk), .i_reset_n(rst_n), .i_fetch_req(f_req), .i_instruction_pointer(adr),
		.i_data_req(d_req), .i_data_write(d_wr), .i_data_wide(d_wide), .i_data_pointer_reg(adr),
		.i_indirect_index_reg(adr[7:0]), .i_wdata(wd), .o_busy(busy), .o_done(done),
		.o_fetch_internal(f_int), .o_rdata(rdata), .i_external_fetch_select_n(sel_n),
		.i_low_port_wr(lw), .i_low_port_wdata(lwd), .i_high_port_wr(hw), .i_high_port_wdata(hwd),
		.o_low_port_latch(lat_lo), .o_high_port_latch(lat_hi), .o_low_port_wr_refused(refused),
		.o_ale(ale), .o_program_fetch_strobe_n(fs_n), .o_read_strobe_pin_n(rd_n),
		.o_write_strobe_pin_n(wr_n), .i_low_addr_data_port(pin), .o_low_addr_data_port(lo),
		.o_low_addr_data_port_oe(lo_oe), .o_high_addr_port(hi), .o_high_addr_port_oe(hi_oe),
		.o_high_addr_port_strong(hi_st));
	emb_mem_model emb_mem_model_i (.i_clk(clk), .i_ale(ale), .i_fs_n(fs_n), .i_rd_n(rd_n),
		.i_wr_n(wr_n), .i_lo(lo), .i_lo_oe(lo_oe), .i_hi(hi), .o_pin(pin), .o_addr(maddr));
	// Compares one value and counts it
	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		checks_done++;
		if (seen !== exp) begin
			miscompares++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask
	// Prints the counts and the verdict
	task automatic close_out();
		$display("checks %0d miscompares %0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	// Moves to just after the next rising edge
	task automatic tick();
		@(posedge clk);
		#10;
	endtask
	// One request held for one edge, then a bounded wait for its answer
	task automatic op(input logic f, w, wide, input logic [15:0] a, input logic [7:0] d,
		input logic intl, chk, input logic [7:0] exp);
		int n;
		notes.push_back({intl, chk, a, exp});
		f_req = f;
		d_req = !f;
		d_wr = w;
		d_wide = wide;
		adr = a;
		wd = d;
		tick();
		f_req = 1'b0;
		d_req = 1'b0;
		for (n = 0; n < 20 && done !== 1'b1 && f_int !== 1'b1; n++)
			tick();
		if (n == 20)
			check("answer", 16'h0000, 16'h0001);
	endtask
	// Pairs each answer with the oldest note
	always begin : watch
		logic [25:0] n;
		@(posedge clk);
		#5;
		if (done === 1'b1 || f_int === 1'b1) begin
			n = notes.pop_front();
			check("internal", 16'(f_int), 16'(n[25]));
			if (done === 1'b1)
				check("address", maddr, n[23:8]);
			// Bus is free again in the cycle that reports completion
			if (done === 1'b1)
				check("busy", 16'(busy), 16'h0000);
			if (n[24])
				check("rdata", 16'(rdata), 16'(n[7:0]));
		end
	end
	// Cuts a hang short
	initial begin
		#(3000 * 100);
		check("watchdog", 16'h0000, 16'h0001);
		close_out();
	end
	// Main sequence
	initial begin
		logic [7:0]  p;
		logic [15:0] a;
		logic [7:0]  d;
		int          i;
		void'($urandom(32'hEEC9654D));
		repeat (10) @(posedge clk);
		#10;
		rst_n = 1'b1;
		tick();
		// External fetches, low latch written during the last one
		sel_n = 1'b0;
		lwd = 8'h5A;
		for (i = 0; i < 4; i++) begin
			a = (i == 0) ? 16'h0000 : 16'($urandom);
			lw = (i == 3);
			op(1'b1, 1'b0, 1'b1, a, 8'h00, 1'b0, 1'b1, ~a[7:0] ^ a[15:8]);
		end
		check("refused", 16'(refused), 16'h0001);
		check("low latch", 16'(lat_lo), 16'h00FF);
		check("high idle", 16'(hi), 16'(a[15:8]));
		check("high idle oe", 16'(hi_oe), 16'h00FF);
		lw = 1'b0;
		$display("test external fetch done");
		// On-chip limit boundary with the select high
		sel_n = 1'b1;
		op(1'b1, 1'b0, 1'b1, 16'h2000, 8'h00, 1'b0, 1'b1, ~8'h00 ^ 8'h20);
		op(1'b1, 1'b0, 1'b1, 16'h1FFF, 8'h00, 1'b1, 1'b0, 8'h00);
		op(1'b1, 1'b0, 1'b1, 16'h0000, 8'h00, 1'b1, 1'b0, 8'h00);
		lw = 1'b1;
		tick();
		lw = 1'b0;
		check("low latch", 16'(lat_lo), 16'h005A);
		check("refused", 16'(refused), 16'h0000);
		$display("test on-chip limit done");
		// Wide writes and reads back to back, page latch untouched
		p = 8'($urandom);
		hw = 1'b1;
		hwd = p;
		tick();
		hw = 1'b0;
		for (i = 0; i < 4; i++) begin
			a = 16'($urandom);
			d = 8'($urandom);
			op(1'b0, 1'b1, 1'b1, a, d, 1'b0, 1'b0, 8'h00);
			if (i == 0)
				check("low latch", 16'(lat_lo), 16'h00FF);
			op(1'b0, 1'b0, 1'b1, a, 8'h00, 1'b0, 1'b1, d);
		end
		check("high latch", 16'(lat_hi), 16'(p));
		check("high pins", 16'(hi), 16'(p));
		check("high oe", 16'(hi_oe), {8'h00, ~p});
		$display("test wide access done");
		// Narrow accesses carry the page latch on the high port
		for (i = 0; i < 4; i++) begin
			a = {p, 8'($urandom)};
			d = 8'($urandom);
			op(1'b0, 1'b1, 1'b0, a, d, 1'b0, 1'b0, 8'h00);
			op(1'b0, 1'b0, 1'b0, a, 8'h00, 1'b0, 1'b1, d);
		end
		$display("test narrow access done");
		close_out();
	end
endmodule
`default_nettype wire
